//--- common/rcd_if.sv
/*
  Link between the command issuer and the descriptor decoder.
  Assumes both ends run on the same clock and use valid/ready handshakes.
*/
`timescale 1ns/1ps
`default_nettype none
interface rcd_if;
  import rcd_pkg::*;
  logic       cmd_valid;
  logic       cmd_ready;
  rcd_cdb_t   cdb;
  logic       sts_valid;
  logic       sts_ready;
  logic [7:0] sts_code;
  logic [3:0] sense_key;
  logic [7:0] asc;
  logic [7:0] ascq;

  modport dev  (input cmd_valid, cdb, sts_ready,
                output cmd_ready, sts_valid, sts_code, sense_key, asc, ascq);
  modport host (output cmd_valid, cdb, sts_ready,
                input cmd_ready, sts_valid, sts_code, sense_key, asc, ascq);
endinterface
`default_nettype wire

//--- common/rcd_pkg.sv
/*
  Shared constants, types and helpers of the read-descriptor decoder.
  Assumes the descriptor travels as 12 bytes with byte 0 in the top bits.
*/
package rcd_pkg;
  localparam int CDB_BYTES = 12;
  localparam int CDB_W     = CDB_BYTES * 8;
  typedef logic [CDB_W-1:0] rcd_cdb_t;

  // Opcodes, byte positions and field layout of byte 1.
  localparam logic [7:0] OP_RD10   = 8'h28;
  localparam logic [7:0] OP_RD12   = 8'hA8;
  localparam int B_OP      = 0;
  localparam int B_CTL     = 1;
  localparam int B_LBA     = 2;
  localparam int B_LEN10   = 7;
  localparam int B_LEN12   = 6;
  localparam int N_LBA     = 4;
  localparam int N_LEN10   = 2;
  localparam int N_LEN12   = 4;
  localparam int F_RDP     = 5;
  localparam int F_DPO     = 4;
  localparam int F_FUA     = 3;
  localparam int F_FUANV   = 1;

  // Protection codes.
  localparam logic [2:0] RDP_NONE  = 3'h0;
  localparam logic [2:0] RDP_ALL   = 3'h1;
  localparam logic [2:0] RDP_REF   = 3'h2;
  localparam logic [2:0] RDP_PASS  = 3'h3;
  localparam logic [2:0] RDP_GRD   = 3'h4;

  // Status bytes, sense keys, additional sense codes and the lowest retention priority.
  localparam logic [7:0] ST_GOOD   = 8'h00;
  localparam logic [7:0] ST_CHECK  = 8'h02;
  localparam logic [3:0] SK_NONE   = 4'h0;
  localparam logic [3:0] SK_ILLEG  = 4'h5;
  localparam logic [3:0] SK_ABORT  = 4'hB;
  localparam logic [7:0] ASC_NONE  = 8'h00;
  localparam logic [7:0] ASC_OPC   = 8'h20;
  localparam logic [7:0] ASC_FIELD = 8'h24;
  localparam logic [7:0] ASC_PI    = 8'h10;
  localparam logic [7:0] ASCQ_GRD  = 8'h01;
  localparam logic [7:0] ASCQ_REF  = 8'h03;
  localparam logic [3:0] PRIO_LOW  = 4'hF;

  // Controller register map, byte offsets, and the two access response codes.
  localparam logic [7:0] A_CDB0    = 8'h00;
  localparam logic [7:0] A_CDB1    = 8'h04;
  localparam logic [7:0] A_CDB2    = 8'h08;
  localparam logic [7:0] A_CTRL    = 8'h0C;
  localparam logic [7:0] A_STAT    = 8'h10;
  localparam logic [7:0] A_SENSE   = 8'h14;
  localparam logic [7:0] A_ISTAT   = 8'h18;
  localparam logic [7:0] A_IMASK   = 8'h1C;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  // One descriptor byte, byte 0 being the most significant.
  function automatic logic [7:0] cdb_byte(rcd_cdb_t c, int k);
    cdb_byte = c[CDB_W-1-8*k -: 8];
  endfunction

  // Big-endian field of up to four bytes, zero extended.
  function automatic logic [31:0] be_field(rcd_cdb_t c, int first, int n);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < n) r = {r[23:0], cdb_byte(c, first + i)};
    end
    be_field = r;
  endfunction
endpackage

//--- core/rcd_dev.sv
/*
  Device end: decodes and validates ten- and twelve-byte read descriptors,
  drives seek, read-ahead and transfer requests, and returns status.
  Assumes media, cache and protection datapaths outside answer with
  one-cycle done pulses and report protection failures with them.
*/
// Added by the designer: register access over AXI4-Lite and the register offsets.
// Summary of operation
// RL1: Opcode 28h; address bytes 2-5, count 7-8.
// RL2: Byte 1: protect code, DPO, FUA, FUA_NV.
// RL3: FUA_NV accepted either way, no effect.
// RL4: Zero count still seeks, no data, no error.
// RL5: Read-ahead starts after seek if enabled.
// RL6: DPO set gives lowest cache retention priority.
// RL7: DPO clear uses configured retention priority.
// RL8: Issuer should set DPO for unreused blocks.
// RL9: FUA set forces reading from the medium.
// RL10: FUA clear allows cache or medium.
// RL11: Unprotected medium with nonzero code: invalid field.
// RL12: Code 000b: no protection check or send.
// RL13: Codes 001b-100b send protection; per-code checks.
// RL14: Application tag is never checked here.
// RL15: Codes 101b-111b rejected as invalid field.
// RL16: Failed check aborts, sense names failed field.
// RL17: Zero count valid descriptor returns Good directly.
// RL18: Opcode A8h; address bytes 2-5, count 6-9.
// RL19: Multi-byte fields are most significant byte first.
`timescale 1ns/1ps
`default_nettype none
module rcd_dev
  import rcd_pkg::*;
#(
  parameter int PRIO_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  rcd_if.dev                     link,
  input  wire logic              pi_formatted,
  input  wire logic              read_ahead_en,
  input  wire logic [PRIO_W-1:0] retain_prio,
  output logic                   seek_req,
  output logic [31:0]            seek_lba,
  input  wire logic              seek_done,
  output logic                   ra_start,
  output logic                   xfer_req,
  output logic [31:0]            xfer_cnt,
  output logic                   media_only,
  output logic [PRIO_W-1:0]      cache_prio,
  output logic                   pi_send,
  output logic                   chk_guard,
  output logic                   chk_ref,
  output logic                   chk_app,
  input  wire logic              xfer_done,
  input  wire logic              guard_fail,
  input  wire logic              ref_fail
);
  import rcd_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_SEEK = 2'b01,
    D_XFER = 2'b10,
    D_STAT = 2'b11
  } rcd_dst_t;

  typedef struct packed {
    rcd_dst_t          st;
    logic [31:0]       lba;
    logic [31:0]       cnt;
    logic              media;
    logic [PRIO_W-1:0] prio;
    logic              send;
    logic              cg;
    logic              cr;
    logic              seek;
    logic              ra;
    logic              xfer;
    logic [7:0]        code;
    logic [3:0]        key;
    logic [7:0]        asc;
    logic [7:0]        ascq;
  } rcd_dreg_t;

  rcd_dreg_t  s_r;
  rcd_dreg_t  s_nxt;
  logic [7:0] op;
  logic [7:0] ctl;
  logic [2:0] rdp;
  logic       is10;
  logic       is12;
  logic       fuanv_unused;

  // Field extraction from the offered descriptor.
  assign op   = cdb_byte(link.cdb, B_OP);
  assign ctl  = cdb_byte(link.cdb, B_CTL);
  assign is10 = (op == OP_RD10); // [RL1]
  assign is12 = (op == OP_RD12); // [RL18]
  // Byte 1 from the top: code, DPO, FUA, reserved, FUA_NV, obsolete. [RL2]
  assign rdp  = ctl[F_RDP+2:F_RDP];
  // No non-volatile cache, so FUA_NV is taken and never looked at. [RL3]
  assign fuanv_unused = ctl[F_FUANV];

  // Outputs come straight from the state record, except chk_app, which is tied low.
  assign link.cmd_ready = (s_r.st == D_IDLE);
  assign link.sts_valid = (s_r.st == D_STAT);
  assign link.sts_code  = s_r.code;
  assign link.sense_key = s_r.key;
  assign link.asc       = s_r.asc;
  assign link.ascq      = s_r.ascq;
  assign seek_req   = s_r.seek;
  assign seek_lba   = s_r.lba;
  assign ra_start   = s_r.ra;
  assign xfer_req   = s_r.xfer;
  assign xfer_cnt   = s_r.cnt;
  assign media_only = s_r.media;
  assign cache_prio = s_r.prio;
  assign pi_send    = s_r.send;
  assign chk_guard  = s_r.cg;
  assign chk_ref    = s_r.cr;
  // The application tag needs the long form's mask and expected value,
  // which these descriptors lack, so it is never checked. [RL14]
  assign chk_app    = 1'b0;

  // Command sequencing: decode, seek, optional transfer, status.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.seek = 1'b0;
    s_nxt.ra   = 1'b0;
    s_nxt.xfer = 1'b0;
    unique case (s_r.st)
      D_IDLE: begin
        if (link.cmd_valid) begin
          s_nxt.code = ST_CHECK;
          s_nxt.key  = SK_ILLEG;
          s_nxt.ascq = ASC_NONE;
          s_nxt.st   = D_STAT;
          if (!is10 && !is12) begin
            s_nxt.asc = ASC_OPC;
          end else if (rdp > RDP_GRD) begin
            s_nxt.asc = ASC_FIELD; // [RL15]
          end else if (!pi_formatted && rdp != RDP_NONE) begin
            s_nxt.asc = ASC_FIELD; // [RL11]
          end else begin
            s_nxt.st   = D_SEEK;
            s_nxt.seek = 1'b1;
            // Address and count are assembled top byte first. [RL19]
            s_nxt.lba  = be_field(link.cdb, B_LBA, N_LBA); // [RL1] [RL18]
            s_nxt.cnt  = is10 ? be_field(link.cdb, B_LEN10, N_LEN10) // [RL1]
                              : be_field(link.cdb, B_LEN12, N_LEN12); // [RL18]
            // FUA set bypasses the cache; clear lets either serve. [RL9] [RL10]
            s_nxt.media = ctl[F_FUA];
            // DPO beats the configured retention priority. [RL6] [RL7]
            s_nxt.prio  = ctl[F_DPO] ? PRIO_LOW[PRIO_W-1:0] : retain_prio;
            // Code zero neither sends nor checks protection. [RL12]
            s_nxt.send  = (rdp != RDP_NONE); // [RL13]
            s_nxt.cg    = (rdp == RDP_ALL) || (rdp == RDP_GRD); // [RL13]
            s_nxt.cr    = (rdp == RDP_ALL) || (rdp == RDP_REF); // [RL13]
          end
        end
      end
      D_SEEK: begin
        if (seek_done) begin
          s_nxt.ra = read_ahead_en; // [RL5]
          if (s_r.cnt == 32'h0) begin
            // Zero count: seek done, no data phase, Good at once. [RL4]
            s_nxt.st   = D_STAT; // [RL17]
            s_nxt.code = ST_GOOD;
            s_nxt.key  = SK_NONE;
            s_nxt.asc  = ASC_NONE;
            s_nxt.ascq = ASC_NONE;
          end else begin
            s_nxt.st   = D_XFER;
            s_nxt.xfer = 1'b1;
          end
        end
      end
      D_XFER: begin
        if (xfer_done) begin
          s_nxt.st = D_STAT;
          // Only enabled checks count; guard is reported first. [RL16]
          if (guard_fail && s_r.cg) begin
            s_nxt.code = ST_CHECK;
            s_nxt.key  = SK_ABORT;
            s_nxt.asc  = ASC_PI;
            s_nxt.ascq = ASCQ_GRD;
          end else if (ref_fail && s_r.cr) begin
            s_nxt.code = ST_CHECK; // [RL16]
            s_nxt.key  = SK_ABORT;
            s_nxt.asc  = ASC_PI;
            s_nxt.ascq = ASCQ_REF;
          end else begin
            s_nxt.code = ST_GOOD;
            s_nxt.key  = SK_NONE;
            s_nxt.asc  = ASC_NONE;
            s_nxt.ascq = ASC_NONE;
          end
        end
      end
      D_STAT: if (link.sts_ready) s_nxt.st = D_IDLE;
    endcase
  end

  // Single register stage; a rejected command never touches the media.
  always_ff @(posedge core_clk) begin
    if (sys_rst) s_r <= '0;
    else         s_r <= s_nxt;
  end
endmodule
`default_nettype wire

//--- core/rcd_host.sv
/*
  Issuer end: software loads a descriptor over AXI4-Lite, starts it, and
  reads back status and sense; a done event raises a maskable interrupt.
  Assumes a device end on the same clock behind the rcd_if link.
*/
`timescale 1ns/1ps
`default_nettype none
module rcd_host
  import rcd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  rcd_if.host              link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import rcd_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10
  } rcd_hst_t;

  typedef struct packed {
    rcd_hst_t    st;
    rcd_cdb_t    cdb;
    logic [7:0]  code;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic        pend;
    logic        mask;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } rcd_hreg_t;

  rcd_hreg_t s_r;
  rcd_hreg_t s_nxt;
  logic      wr_go;
  logic      rd_go;

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                        logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    merge = r;
  endfunction

  // Address and data are taken together, so no half write is ever held.
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_r.bvalid;
  assign rd_go         = s_axi_arvalid && !s_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;
  assign irq           = s_r.pend && s_r.mask;
  assign link.cmd_valid = (s_r.st == H_SEND);
  assign link.cdb       = s_r.cdb;
  assign link.sts_ready = (s_r.st == H_WAIT);

  // Register access, link sequencing and the done flag.
  always_comb begin
    s_nxt = s_r;
    if (s_axi_bready) s_nxt.bvalid = 1'b0;
    if (s_axi_rready) s_nxt.rvalid = 1'b0;
    if (wr_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OK;
      unique case (s_axi_awaddr)
        // Word k holds bytes 4k..4k+3, lowest byte index on top. [RL19]
        A_CDB0: s_nxt.cdb[95:64] = merge(s_r.cdb[95:64], s_axi_wdata,
                                         s_axi_wstrb);
        A_CDB1: s_nxt.cdb[63:32] = merge(s_r.cdb[63:32], s_axi_wdata,
                                         s_axi_wstrb);
        A_CDB2: s_nxt.cdb[31:0]  = merge(s_r.cdb[31:0], s_axi_wdata,
                                         s_axi_wstrb);
        A_CTRL: begin
          // A start while busy is dropped; the descriptor is still latched.
          if (s_axi_wdata[0] && s_r.st == H_IDLE) s_nxt.st = H_SEND;
        end
        A_ISTAT: if (s_axi_wdata[0]) s_nxt.pend = 1'b0;
        A_IMASK: s_nxt.mask = s_axi_wdata[0];
        A_STAT, A_SENSE: ;
        default: s_nxt.bresp = RESP_ERR;
      endcase
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OK;
      unique case (s_axi_araddr)
        A_CDB0:  s_nxt.rdata = s_r.cdb[95:64];
        A_CDB1:  s_nxt.rdata = s_r.cdb[63:32];
        A_CDB2:  s_nxt.rdata = s_r.cdb[31:0];
        A_CTRL:  s_nxt.rdata = 32'h0;
        A_STAT:  s_nxt.rdata = {12'h0, s_r.key, s_r.code, 7'h0,
                                 s_r.st != H_IDLE};
        A_SENSE: s_nxt.rdata = {16'h0, s_r.asc, s_r.ascq};
        A_ISTAT: s_nxt.rdata = {31'h0, s_r.pend};
        A_IMASK: s_nxt.rdata = {31'h0, s_r.mask};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = RESP_ERR;
        end
      endcase
    end
    unique case (s_r.st)
      H_IDLE: ;
      H_SEND: if (link.cmd_ready) s_nxt.st = H_WAIT;
      // The fourth code is never entered; falling back to idle recovers.
      default: s_nxt.st = H_IDLE;
      H_WAIT: begin
        if (link.sts_valid) begin
          s_nxt.st   = H_IDLE;
          s_nxt.code = link.sts_code;
          s_nxt.key  = link.sense_key;
          s_nxt.asc  = link.asc;
          s_nxt.ascq = link.ascq;
          s_nxt.pend = 1'b1; // Placed last so the event beats a clear.
        end
      end
    endcase
  end

  // Single register stage for all state.
  always_ff @(posedge core_clk) begin
    if (sys_rst) s_r <= '0;
    else         s_r <= s_nxt;
  end
endmodule
`default_nettype wire

//--- verification/rcd_assertions.sv
/*
  Checker of the link between the issuer end and the decoder end.
  Assumes plain link signals plus the shared clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rcd_assertions (
  input wire logic             core_clk,
  input wire logic             sys_rst,
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire rcd_pkg::rcd_cdb_t cdb,
  input wire logic             sts_valid,
  input wire logic             sts_ready,
  input wire logic [7:0]       sts_code,
  input wire logic [3:0]       sense_key,
  input wire logic [7:0]       asc,
  input wire logic [7:0]       ascq
);
  import rcd_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Opcode and protection code of the descriptor offered on the link.
  logic       take;
  logic       known;
  logic [2:0] rdp;
  assign take  = cmd_valid && cmd_ready;
  assign known = (cdb[95:88] == OP_RD10) || (cdb[95:88] == OP_RD12);
  assign rdp   = cdb[87:85];

  a_bad_opcode: assert property (take && !known |=> sts_valid && sts_code == ST_CHECK && sense_key == SK_ILLEG && asc == ASC_OPC)
    else $error("unknown opcode not rejected");
  a_reserved_code: assert property (take && known && rdp > 3'h4 |=> sts_valid && sense_key == SK_ILLEG && asc == ASC_FIELD)
    else $error("reserved protection code not rejected");
  a_plain_proceeds: assert property (take && known && rdp == RDP_NONE |=> !sts_valid)
    else $error("plain read answered before its seek");
  a_take_busy: assert property (take |=> !cmd_ready)
    else $error("second descriptor accepted while busy");
  a_status_holds: assert property (sts_valid && !sts_ready |=> sts_valid && $stable({sts_code, sense_key, asc, ascq}))
    else $error("status changed before it was taken");
  a_idle_after: assert property (sts_valid && sts_ready |=> cmd_ready && !sts_valid)
    else $error("decoder not idle after status taken");
  a_status_excl: assert property (sts_valid |-> !cmd_ready)
    else $error("ready while status pending");
  a_good_clean: assert property (sts_valid && sts_code == ST_GOOD |-> sense_key == SK_NONE && asc == ASC_NONE && ascq == 8'h00)
    else $error("good status carries sense data");
  a_abort_sense: assert property (sts_valid && sense_key == SK_ABORT |-> sts_code == ST_CHECK && asc == ASC_PI && (ascq == ASCQ_GRD || ascq == ASCQ_REF))
    else $error("aborted command without field sense");

  // Main outcomes that the bench is expected to reach.
  c_bad_opcode: cover property (take && !known);
  c_abort: cover property (sts_valid && sense_key == SK_ABORT);
  c_good: cover property (sts_valid && sts_code == ST_GOOD);
endmodule
`default_nettype wire

//--- verification/scsi_read_cdb_decoder_bench.sv
/*
  Self-checking bench: the issuer and decoder ends joined by one link.
  Assumes software access over AXI4-Lite and a media side played here.
*/
`timescale 1ns/1ps
`default_nettype none
module scsi_read_cdb_decoder_bench;
  import rcd_pkg::*;
  logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, imask;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seek_lba, xfer_cnt, c_lba, c_cnt;
  logic [1:0]  bresp, rresp, lb;
  logic        pi_fmt, ra_en, seek_req, seek_done, ra_start, xfer_req;
  logic        xfer_done, media_only, pi_send, chk_guard, chk_ref, chk_app;
  logic        gfail, rfail;
  logic [3:0]  retain, cache_prio, c_prio;
  logic [4:0]  c_flg;
  logic [2:0]  sk_d;
  logic [1:0]  xf_d;
  int          ra_n, xf_n, errors, cmp_count;

  rcd_if link ();
  rcd_host u_rcd_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  rcd_dev #(.PRIO_W(4)) u_rcd_dev (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link.dev), .pi_formatted(pi_fmt), .read_ahead_en(ra_en),
    .retain_prio(retain), .seek_req(seek_req), .seek_lba(seek_lba),
    .seek_done(seek_done), .ra_start(ra_start), .xfer_req(xfer_req),
    .xfer_cnt(xfer_cnt), .media_only(media_only), .cache_prio(cache_prio),
    .pi_send(pi_send), .chk_guard(chk_guard), .chk_ref(chk_ref),
    .chk_app(chk_app), .xfer_done(xfer_done), .guard_fail(gfail),
    .ref_fail(rfail));
  rcd_assertions u_rcd_assertions (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cdb(link.cdb),
    .sts_valid(link.sts_valid), .sts_ready(link.sts_ready),
    .sts_code(link.sts_code), .sense_key(link.sense_key), .asc(link.asc),
    .ascq(link.ascq));

  // Free-running device clock at 20 MHz.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Media side: seeks finish four cycles after the request, transfers three, so
  // the decoder never sees an answer in the cycle of its own request.
  always @(posedge core_clk) begin
    sk_d      <= {sk_d[1:0], seek_req};
    xf_d      <= {xf_d[0], xfer_req};
    seek_done <= sk_d[2];
    xfer_done <= xf_d[1];
    if (seek_req) begin
      c_lba  <= seek_lba;
      c_cnt  <= xfer_cnt;
      c_prio <= cache_prio;
      c_flg  <= {media_only, pi_send, chk_guard, chk_ref, chk_app};
    end
    // Counts restart at each take, so each command is judged on its own.
    if (link.cmd_valid && link.cmd_ready) begin
      ra_n <= 0;
      xf_n <= 0;
    end else begin
      if (ra_start) ra_n <= ra_n + 1;
      if (xfer_req) xf_n <= xf_n + 1;
    end
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Cuts a hung handshake short; the run ends in the verdict.
  task automatic hang(input int n);
    if (n >= 100) begin
      chk("handshake", 1, 0);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (awready !== 1'b1 && n < 100);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    lb = bresp;
    bready <= 1'b0;
    hang(n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    hang(n);
  endtask

  function automatic rcd_cdb_t c10(logic [7:0] b1, logic [31:0] a,
                                   logic [15:0] n);
    return {OP_RD10, b1, a, 8'h00, n, 24'h0};
  endfunction

  function automatic rcd_cdb_t c12(logic [7:0] b1, logic [31:0] a, n);
    return {OP_RD12, b1, a, n, 16'h0};
  endfunction

  // Loads and starts a descriptor, polls the done event, checks status,
  // sense and the interrupt line, then clears the event.
  task automatic run(input rcd_cdb_t c, input logic [7:0] st,
                     input logic [3:0] sk, input logic [15:0] sn);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(A_CDB0, c[95:64]);
    wr(A_CDB1, c[63:32]);
    wr(A_CDB2, c[31:0]);
    wr(A_CTRL, 32'h1);
    d = 32'h0;
    for (n = 0; n < 100 && d[0] !== 1'b1; n++) rd(A_ISTAT, d, r);
    hang(n);
    chk("irq", imask, irq);
    rd(A_STAT, d, r);
    chk("status", {sk, st, 1'b0}, {d[19:8], d[0]});
    rd(A_SENSE, d, r);
    chk("sense", sn, d[15:0]);
    wr(A_ISTAT, 32'h1);
    rd(A_ISTAT, d, r);
    chk("event clear", 0, {d[0], irq});
  endtask

  // Media-only and protection send/check flags expected for a protection code.
  function automatic logic [4:0] pflg(logic [2:0] p);
    case (p)
      3'h1: return 5'b01110;
      3'h2: return 5'b01010;
      3'h3: return 5'b01000;
      3'h4: return 5'b01100;
      default: return 5'b00000;
    endcase
  endfunction

  task automatic t_read10;
    ra_en <= 1'b1;
    run(c10(8'h1A, 32'h1234_5678, 16'hA5B6), ST_GOOD, SK_NONE, 0);
    chk("lba", 32'h1234_5678, c_lba);
    chk("count", 32'h0000_A5B6, c_cnt);
    chk("flags", 5'b10000, c_flg);
    chk("prio", PRIO_LOW, c_prio);
    chk("transfers", 1, xf_n);
    chk("read ahead", 1, ra_n);
    $display("t_read10 done");
  endtask

  task automatic t_read12;
    ra_en <= 1'b0;
    run(c12(8'h00, 32'hFEDC_BA98, 32'h0102_0304), ST_GOOD, SK_NONE, 0);
    chk("lba", 32'hFEDC_BA98, c_lba);
    chk("count", 32'h0102_0304, c_cnt);
    chk("flags", 5'b00000, c_flg);
    chk("prio", 4'h6, c_prio);
    chk("read ahead", 0, ra_n);
    $display("t_read12 done");
  endtask

  task automatic t_zero;
    ra_en <= 1'b1;
    run(c10(8'h02, 32'h0000_0040, 16'h0), ST_GOOD, SK_NONE, 0);
    chk("seek lba", 32'h0000_0040, c_lba);
    chk("transfers", 0, xf_n);
    chk("read ahead", 1, ra_n);
    $display("t_zero done");
  endtask

  task automatic t_protect;
    for (int p = 0; p < 8; p++) begin
      if (p > 4) run(c12({p[2:0], 5'h0}, 32'h10, 32'h1), ST_CHECK, SK_ILLEG, {ASC_FIELD, 8'h00});
      else run(c12({p[2:0], 5'h0}, 32'h10, 32'h1), ST_GOOD, SK_NONE, 0);
      if (p < 5) chk("pi flags", pflg(p[2:0]), c_flg);
    end
    pi_fmt <= 1'b0;
    run(c10(8'h60, 32'h20, 16'h1), ST_CHECK, SK_ILLEG, {ASC_FIELD, 8'h00});
    run(c10(8'h00, 32'h20, 16'h1), ST_GOOD, SK_NONE, 0);
    pi_fmt <= 1'b1;
    $display("t_protect done");
  endtask

  task automatic fl(input logic [2:0] p, input logic g, f, bad,
                    input logic [7:0] q);
    gfail <= g;
    rfail <= f;
    run(c10({p, 5'h0}, 32'h100, 16'h2), bad ? ST_CHECK : ST_GOOD, bad ? SK_ABORT : SK_NONE, bad ? {ASC_PI, q} : 16'h0);
  endtask

  // Failures of enabled checks abort; failures of disabled ones pass.
  task automatic t_fail;
    fl(3'h1, 1'b1, 1'b0, 1'b1, ASCQ_GRD);
    fl(3'h1, 1'b0, 1'b1, 1'b1, ASCQ_REF);
    fl(3'h4, 1'b1, 1'b1, 1'b1, ASCQ_GRD);
    fl(3'h2, 1'b1, 1'b0, 1'b0, 8'h00);
    fl(3'h4, 1'b0, 1'b1, 1'b0, 8'h00);
    fl(3'h3, 1'b1, 1'b1, 1'b0, 8'h00);
    gfail <= 1'b0;
    rfail <= 1'b0;
    $display("t_fail done");
  endtask

  // Masked event on a bad opcode, then unmapped register accesses.
  task automatic t_irq_map;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_IMASK, 32'h0);
    imask = 1'b0;
    run({8'h2A, 88'h0}, ST_CHECK, SK_ILLEG, {ASC_OPC, 8'h00});
    rd(8'h20, d, r);
    chk("unmapped rresp", RESP_ERR, r);
    chk("unmapped rdata", 32'h0, d);
    wr(8'h24, 32'h5);
    chk("unmapped write", RESP_ERR, lb);
    $display("t_irq_map done");
  endtask

  // Main sequence: reset for eight cycles, enable the event, run tests.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {gfail, rfail} = 2'h0;
    {pi_fmt, ra_en, retain, imask} = {1'b1, 1'b1, 4'h6, 1'b1};
    {errors, cmp_count} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    wr(A_IMASK, 32'h1);
    t_read10;
    t_read12;
    t_zero;
    t_protect;
    t_fail;
    t_irq_map;
    results();
  end
endmodule
`default_nettype wire
